// ### rtl/rac_regs.svh
`ifndef RAC_REGS_SVH
`define RAC_REGS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RAC_OFS_COUNT_INFO   32'hE000_ED90
`define RAC_OFS_CONTROL      32'hE000_ED94
`define RAC_OFS_SELECT       32'hE000_ED98
`define RAC_OFS_BASE         32'hE000_ED9C
`define RAC_OFS_LIMIT        32'hE000_EDA0
`define RAC_OFS_BASE_A1      32'hE000_EDA4
`define RAC_OFS_LIMIT_A1     32'hE000_EDA8
`define RAC_OFS_BASE_A2      32'hE000_EDAC
`define RAC_OFS_LIMIT_A2     32'hE000_EDB0
`define RAC_OFS_BASE_A3      32'hE000_EDB4
`define RAC_OFS_LIMIT_A3     32'hE000_EDB8
`define RAC_OFS_ATTR_LOW     32'hE000_EDC0
`define RAC_OFS_ATTR_HIGH    32'hE000_EDC4
`define RAC_OFS_FAULT_STATUS 32'hE000_EDC8
`define RAC_OFS_FAULT_ADDR   32'hE000_EDCC
// ----------------------------------------
// field positions
// ----------------------------------------
`define RAC_CTRL_ENABLE_BIT  0
`define RAC_CTRL_HANDLER_BIT 1
`define RAC_CTRL_BGMAP_BIT   2
`define RAC_BASE_XN_BIT      0
`define RAC_BASE_AP_LO       1
`define RAC_LIMIT_EN_BIT     0
`define RAC_LIMIT_IDX_LO     1
`define RAC_LIMIT_PXN_BIT    4
`define RAC_GRAIN_LSB        5
`define RAC_FS_IACC_BIT      0
`define RAC_FS_DACC_BIT      1
`define RAC_FS_VALID_BIT     7
// ----------------------------------------
// reset values
// ----------------------------------------
`define RAC_RST_WORD         32'h0000_0000
`endif

// ### rtl/rac_pkg.sv
package rac_pkg;
    // one access presented by the core
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        write;
        logic        fetch;
        logic        priv;
    } rac_req_t;
    // per-region stored settings
    typedef struct packed {
        logic [26:0] base;
        logic [1:0]  ap;
        logic        xn;
        logic [26:0] limit;
        logic        privileged_execute_never;
        logic [2:0]  idx;
        logic        en;
    } rac_region_t;
    // register slave request
    typedef struct packed {
        logic        sel;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rac_bus_t;
    // checker decision state
    typedef enum logic [1:0] {
        RAC_IDLE = 2'b00,
        RAC_PASS = 2'b01,
        RAC_FAIL = 2'b11
    } rac_state_t;
endpackage

// ### rtl/rac_region_checker.sv
`timescale 1ns/10ps
`include "rac_regs.svh"

module rac_region_checker #(
    parameter int  REGIONS  = 8,     // implemented regions, 0 to 8
    parameter bit  MAIN_EXT = 1'b1   // dedicated management fault present
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire rac_pkg::rac_req_t acc_req,
    input  wire logic              acc_high_handler,
    input  wire logic              mm_fault_enabled,
    input  wire logic              mm_fault_can_take,
    input  wire rac_pkg::rac_bus_t reg_bus,
    output logic [31:0]            reg_rdata,
    output logic                   acc_grant,
    output logic                   acc_block,
    output logic [7:0]             acc_attr,
    output logic                   acc_default_map,
    output logic                   memory_management_fault,
    output logic                   hard_fault_a
);
    // ----------------------------------------
    // configuration storage
    // ----------------------------------------
    localparam int RW = (REGIONS > 1) ? $clog2(REGIONS) : 1;
    rac_pkg::rac_region_t region_ff [REGIONS];  // one entry per region
    logic [2:0]   ctrl_ff;                      // enable, handler, bgmap
    logic [7:0]   select_ff;                    // region selected for access
    logic [63:0]  attr_ff;                      // eight attribute bytes
    logic [7:0]   fstat_ff;                     // fault cause record
    logic [31:0]  faddr_ff;                     // data fault address

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire        wr        = reg_bus.sel & reg_bus.write;
    wire [31:0] a         = reg_bus.addr;
    wire        hit_ctrl  = (a == `RAC_OFS_CONTROL);
    wire        hit_sel   = (a == `RAC_OFS_SELECT);
    wire        hit_attl  = (a == `RAC_OFS_ATTR_LOW);
    wire        hit_atth  = (a == `RAC_OFS_ATTR_HIGH);
    // which of base/limit pairs, and alias offset n
    wire        is_base   = (a == `RAC_OFS_BASE) | (a == `RAC_OFS_BASE_A1) |
                            (a == `RAC_OFS_BASE_A2) | (a == `RAC_OFS_BASE_A3);
    wire        is_limit  = (a == `RAC_OFS_LIMIT) | (a == `RAC_OFS_LIMIT_A1) |
                            (a == `RAC_OFS_LIMIT_A2) | (a == `RAC_OFS_LIMIT_A3);
    wire [1:0]  alias_n   = (a == `RAC_OFS_BASE_A1 || a == `RAC_OFS_LIMIT_A1) ? 2'd1 :
                            (a == `RAC_OFS_BASE_A2 || a == `RAC_OFS_LIMIT_A2) ? 2'd2 :
                            (a == `RAC_OFS_BASE_A3 || a == `RAC_OFS_LIMIT_A3) ? 2'd3 : 2'd0;
    // plain pair uses select directly, aliases replace low two bits
    wire [7:0]  target    = (alias_n == 2'd0) ? select_ff : {select_ff[7:2], alias_n};
    wire        tgt_ok    = ({24'h0, target} < 32'(REGIONS));
    wire [RW-1:0] tgt_idx = target[RW-1:0];

    // ----------------------------------------
    // control, select and attribute writes
    // ----------------------------------------
    // reset clears global enable and all region enables
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctrl_ff   <= 3'b000;
            select_ff <= 8'h00;
            attr_ff   <= 64'h0;
        end
        else
        begin
            if (wr && hit_ctrl) ctrl_ff <= reg_bus.wdata[2:0];
            if (wr && hit_sel)  select_ff <= reg_bus.wdata[7:0];
            if (wr && hit_attl) attr_ff[31:0] <= reg_bus.wdata;
            if (wr && hit_atth) attr_ff[63:32] <= reg_bus.wdata;
        end
    end

    // ----------------------------------------
    // per-region storage and matching
    // ----------------------------------------
    logic [REGIONS-1:0] hit_vec;  // address lies inside enabled region
    genvar g;
    generate
        for (g = 0; g < REGIONS; g++)
        begin : g_region
            wire sel_me = tgt_ok && (tgt_idx == RW'(g));
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                    region_ff[g] <= '0;
                else if (wr && is_base && sel_me)
                begin
                    // low five bits are dropped: 32 byte granule
                    region_ff[g].base <= reg_bus.wdata[31:`RAC_GRAIN_LSB];
                    region_ff[g].ap   <= reg_bus.wdata[`RAC_BASE_AP_LO +: 2];
                    region_ff[g].xn   <= reg_bus.wdata[`RAC_BASE_XN_BIT];
                end
                else if (wr && is_limit && sel_me)
                begin
                    region_ff[g].limit <= reg_bus.wdata[31:`RAC_GRAIN_LSB];
                    region_ff[g].privileged_execute_never   <= reg_bus.wdata[`RAC_LIMIT_PXN_BIT];
                    region_ff[g].idx   <= reg_bus.wdata[`RAC_LIMIT_IDX_LO +: 3];
                    region_ff[g].en    <= reg_bus.wdata[`RAC_LIMIT_EN_BIT];
                end
            end
            // inclusive compare, limit low bits read as ones
            assign hit_vec[g] = region_ff[g].en &&
                                (acc_req.addr[31:5] >= region_ff[g].base) &&
                                (acc_req.addr[31:5] <= region_ff[g].limit);
        end
    endgenerate

    // ----------------------------------------
    // access decision
    // ----------------------------------------
    // the one hit region, found by a small priority scan
    logic [RW-1:0] hit_idx;
    always_comb
    begin
        hit_idx = '0;
        for (int i = REGIONS - 1; i >= 0; i--)
            if (hit_vec[i]) hit_idx = RW'(i);
    end
    wire        n_hit   = |hit_vec;
    wire        multi   = (hit_vec & (hit_vec - 1'b1)) != '0;
    wire rac_pkg::rac_region_t r = region_ff[hit_idx];
    // checks apply only with enable set, and inside high handlers only with the handler bit set
    wire        active  = ctrl_ff[`RAC_CTRL_ENABLE_BIT] &&
                          (!acc_high_handler || ctrl_ff[`RAC_CTRL_HANDLER_BIT]);
    // ap[1] = read-only, ap[0] = unprivileged allowed
    wire        perm_ok = (acc_req.priv || r.ap[0]) && !(acc_req.write && r.ap[1]);
    wire        exec_ok = !acc_req.fetch ||
                          (!r.xn && !(acc_req.priv && r.privileged_execute_never));
    wire        bg_ok   = acc_req.priv && ctrl_ff[`RAC_CTRL_BGMAP_BIT];
    wire        viol    = active && (multi || (n_hit && !(perm_ok && exec_ok)) ||
                                     (!n_hit && !bg_ok));
    wire        use_def = !active || (!n_hit && bg_ok);

    // blocking is combinational so the transfer never leaves
    assign acc_block = acc_req.valid && viol;
    assign acc_grant = acc_req.valid && !viol;

    // ----------------------------------------
    // attribute export and fault outputs
    // ----------------------------------------
    rac_pkg::rac_state_t st_ff;   // last decision, for visibility
    wire route_mm = MAIN_EXT && mm_fault_enabled && mm_fault_can_take;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            acc_attr                <= 8'h00;
            acc_default_map         <= 1'b1;
            memory_management_fault <= 1'b0;
            hard_fault_a            <= 1'b0;
            st_ff                   <= rac_pkg::RAC_IDLE;
        end
        else
        begin
            // selected byte of the attribute table
            acc_attr                <= use_def ? 8'h00 : attr_ff[{r.idx, 3'b000} +: 8];
            acc_default_map         <= use_def;
            memory_management_fault <= acc_block && route_mm;
            hard_fault_a            <= acc_block && !route_mm;
            case (st_ff)
                default: st_ff <= !acc_req.valid ? rac_pkg::RAC_IDLE :
                                  viol ? rac_pkg::RAC_FAIL : rac_pkg::RAC_PASS;
            endcase
        end
    end

    // ----------------------------------------
    // fault record
    // ----------------------------------------
    // a new fault overwrites the status, a data fault also the address; record holds until next fault
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            fstat_ff <= 8'h00;
            faddr_ff <= 32'h0000_0000;
        end
        else if (acc_block)
        begin
            fstat_ff <= {1'b1, 5'b0, !acc_req.fetch, acc_req.fetch};
            if (!acc_req.fetch) faddr_ff <= acc_req.addr;
        end
    end

    // ----------------------------------------
    // read mux, registers are in system space
    // ----------------------------------------
    wire rac_pkg::rac_region_t t = tgt_ok ? region_ff[tgt_idx] : '0;
    wire [31:0] rd_next =
        (a == `RAC_OFS_COUNT_INFO)   ? {16'h0, 8'(REGIONS), 8'h0} :
        hit_ctrl                     ? {29'h0, ctrl_ff} :
        hit_sel                      ? {24'h0, select_ff} :
        is_base                      ? {t.base, 2'b00, t.ap, t.xn} :
        is_limit                     ? {t.limit, t.privileged_execute_never, t.idx, t.en} :
        hit_attl                     ? attr_ff[31:0] :
        hit_atth                     ? attr_ff[63:32] :
        (a == `RAC_OFS_FAULT_STATUS) ? {24'h0, fstat_ff} :
        (a == `RAC_OFS_FAULT_ADDR)   ? faddr_ff : 32'h0000_0000;
    always_ff @(posedge clk)
    begin
        if (!reset_n) reg_rdata <= `RAC_RST_WORD;
        else          reg_rdata <= (reg_bus.sel && !reg_bus.write) ? rd_next : 32'h0;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_disabled_no_block: assert property (!ctrl_ff[0] |-> !acc_block)
        else $error("block while unit disabled");
    a_multi_hit_fault: assert property (acc_req.valid && active && multi |-> acc_block)
        else $error("overlap not faulted");
    a_fault_reported: assert property (acc_block |=> (memory_management_fault ^ hard_fault_a))
        else $error("block without fault");
    a_no_main_hard: assert property (!MAIN_EXT |-> !memory_management_fault)
        else $error("management fault without main extension");
    a_escalate_hard: assert property (acc_block && !mm_fault_enabled |=> hard_fault_a)
        else $error("fault not escalated");
    a_xn_fetch_block: assert property (acc_req.valid && active && n_hit && !multi &&
                                       acc_req.fetch && r.xn |-> acc_block)
        else $error("fetch from execute never region");
    a_bg_priv_pass: assert property (acc_req.valid && active && !n_hit && bg_ok |-> acc_grant)
        else $error("background map not honoured");
    a_data_addr_kept: assert property (acc_block && !acc_req.fetch |=> faddr_ff == $past(acc_req.addr))
        else $error("fault address not captured");
    a_handler_bypass: assert property (acc_high_handler && !ctrl_ff[1] |-> !acc_block)
        else $error("checked inside high handler");
    c_grant: cover property (acc_grant && n_hit);
    c_block: cover property (acc_block && !multi);
    c_overlap: cover property (acc_block && multi);
    c_bg: cover property (acc_grant && !n_hit && active);
    c_pxn: cover property (acc_block && acc_req.fetch && acc_req.priv && r.privileged_execute_never && !r.xn);

    // ----------------------------------------
    // decision path checks
    // ----------------------------------------
    // grant and block never show together
    a_grant_block_excl: assert property (!(acc_grant && acc_block))
        else $error("grant and block together");

    // no request, no decision
    a_idle_no_decision: assert property (!acc_req.valid |-> !acc_grant && !acc_block)
        else $error("decision without request");

    // every request gets exactly one answer in its own cycle
    a_valid_decided: assert property (acc_req.valid |-> acc_grant ^ acc_block)
        else $error("request left undecided");

    // a granted or absent access leaves both fault lines low
    a_no_spurious_fault: assert property (!acc_block |=> !memory_management_fault && !hard_fault_a)
        else $error("fault without block");

    // routable faults go to the management fault line
    a_mm_routed: assert property (acc_block && route_mm |=> memory_management_fault)
        else $error("management fault not raised");

    // too high a priority pushes the fault to hard
    a_priority_hard: assert property (acc_block && !mm_fault_can_take |=> hard_fault_a)
        else $error("priority escalation missing");

    // ----------------------------------------
    // permission checks on a single hit and on a miss
    // ----------------------------------------
    // unprivileged access to a privileged-only region
    a_unpriv_perm: assert property (acc_req.valid && active && n_hit && !multi &&
                                    !acc_req.priv && !r.ap[0] |-> acc_block)
        else $error("unprivileged access let through");

    // write into a read-only region
    a_readonly_write: assert property (acc_req.valid && active && n_hit && !multi &&
                                       acc_req.write && r.ap[1] |-> acc_block)
        else $error("write to read-only region let through");

    // privileged fetch from a privileged execute never region
    a_pxn_fetch: assert property (acc_req.valid && active && n_hit && !multi &&
                                  acc_req.fetch && acc_req.priv && r.privileged_execute_never |-> acc_block)
        else $error("privileged fetch from pxn region");

    // with checking active, an unprivileged miss always faults, background map or not
    a_miss_unpriv: assert property (acc_req.valid && active && !n_hit && !acc_req.priv |-> acc_block)
        else $error("unprivileged miss let through");

    // ----------------------------------------
    // default map and attribute export
    // ----------------------------------------
    // a disabled unit leaves every access on the default map
    a_default_when_off: assert property (acc_req.valid && !ctrl_ff[0] |=> acc_default_map)
        else $error("default map not used while disabled");

    // bypassed handler accesses use the default map
    a_bypass_default: assert property (acc_req.valid && acc_high_handler && !ctrl_ff[1] |=>
                                       acc_default_map)
        else $error("handler access not bypassed");

    // default map accesses carry no region attribute
    a_attr_default_zero: assert property (acc_default_map |-> acc_attr == 8'h00)
        else $error("attribute exported on default map");

    // ----------------------------------------
    // fault record and state
    // ----------------------------------------
    // every block marks the record valid
    a_status_valid: assert property (acc_block |=> fstat_ff[7])
        else $error("fault record not marked valid");

    // a fetch fault names the instruction side only
    a_fetch_cause: assert property (acc_block && acc_req.fetch |=> fstat_ff[0] && !fstat_ff[1])
        else $error("fetch fault cause wrong");

    // fetch faults leave the data address alone
    a_fetch_addr_kept: assert property (acc_block && acc_req.fetch |=> $stable(faddr_ff))
        else $error("fault address changed on fetch");

    // decision state follows the outcome
    a_fail_state: assert property (acc_block |=> st_ff == rac_pkg::RAC_FAIL)
        else $error("state missed a block");
    a_pass_state: assert property (acc_grant |=> st_ff == rac_pkg::RAC_PASS)
        else $error("state missed a grant");

    // ----------------------------------------
    // register side checks
    // ----------------------------------------
    // read data is zero outside a read answer
    a_rdata_idle_zero: assert property (!(reg_bus.sel && !reg_bus.write) |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside a read");

    // count register reports the built region count
    a_count_read: assert property (reg_bus.sel && !reg_bus.write && a == `RAC_OFS_COUNT_INFO |=>
                                   reg_rdata[15:8] == 8'(REGIONS))
        else $error("region count misreported");

    // a control write takes effect on the next cycle
    a_ctrl_write: assert property (wr && hit_ctrl |=> ctrl_ff == $past(reg_bus.wdata[2:0]))
        else $error("control write lost");

    // alias access never moves the select register
    a_select_kept: assert property (wr && (is_base || is_limit) && alias_n != 2'd0 |=>
                                    select_ff == $past(select_ff))
        else $error("alias access moved the select");
endmodule

// ### verification/rac_core_model.sv
`timescale 1ns/10ps

// -----------------------------------------------
// core side: fetch and load/store request source
// -----------------------------------------------
module rac_core_model (
    input  wire logic         clk,
    output rac_pkg::rac_req_t acc_req
);
    // idle at time zero, no request pending
    initial acc_req = '0;

    // present one access just after an edge and hold it for the whole cycle
    task automatic drive(input logic [31:0] addr, input logic wr, input logic fe, input logic pr);
        @(posedge clk);
        acc_req <= '{valid: 1'b1, addr: addr, write: wr, fetch: fe, priv: pr};
    endtask

    // release at the taking edge; qualifiers flip so a stale value never looks live
    task automatic idle();
        acc_req <= '{valid: 1'b0, addr: ~acc_req.addr, write: ~acc_req.write,
                     fetch: ~acc_req.fetch, priv: ~acc_req.priv};
    endtask
endmodule

// ### verification/tb.sv
`timescale 1ns/10ps
`include "rac_regs.svh"

// -----------------------------------------------
// testbench top
// -----------------------------------------------
module tb;
    logic              clk = 1'b0;               // 125 MHz core clock
    logic              reset_n = 1'b0;           // synchronous, active low
    logic              acc_high_handler = 1'b0;  // core in a high priority handler
    logic              mm_fault_enabled = 1'b1;  // management fault enabled in core
    logic              mm_fault_can_take = 1'b1; // priority allows management fault
    rac_pkg::rac_bus_t reg_bus = '0;             // register access from the core
    rac_pkg::rac_req_t acc_req;                  // access from the core model
    logic [31:0]       reg_rdata;
    logic              acc_grant;
    logic              acc_block;
    logic [7:0]        acc_attr;
    logic              acc_default_map;
    logic              memory_management_fault;
    logic              hard_fault_a;
    int                num_errors = 0;
    int                n_tests = 0;
    // table rows: address, write, fetch, privileged, blocked
    localparam logic [35:0] TAB [10] = '{
        {32'h2000_0000, 4'b0010}, {32'h2000_03DF, 4'b1010}, {32'h2000_03E0, 4'b0011},
        {32'h2000_0000, 4'b0001}, {32'h3000_0FFF, 4'b0000}, {32'h3000_0000, 4'b1001},
        {32'h3000_0000, 4'b0101}, {32'h3000_1000, 4'b0011}, {32'h2000_0040, 4'b0110},
        {32'h4000_0000, 4'b0011}};

    always #4 clk = ~clk;

    rac_core_model u_rac_core_model (.clk(clk), .acc_req(acc_req));

    rac_region_checker #(.REGIONS(8), .MAIN_EXT(1'b1)) u_rac_region_checker (
        .clk(clk), .reset_n(reset_n), .acc_req(acc_req), .acc_high_handler(acc_high_handler),
        .mm_fault_enabled(mm_fault_enabled), .mm_fault_can_take(mm_fault_can_take),
        .reg_bus(reg_bus), .reg_rdata(reg_rdata), .acc_grant(acc_grant), .acc_block(acc_block),
        .acc_attr(acc_attr), .acc_default_map(acc_default_map),
        .memory_management_fault(memory_management_fault), .hard_fault_a(hard_fault_a));

    // -----------------------------------------------
    // shared tasks
    // -----------------------------------------------
    // single comparison point; four-state compare so unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle register access; read data shows just after the taking edge, checked 1 ns later
    task automatic reg_op(input logic wr, input logic [31:0] addr, input logic [31:0] val);
        @(posedge clk);
        reg_bus <= '{sel: 1'b1, write: wr, addr: addr, wdata: val};
        @(posedge clk);
        reg_bus <= '{sel: 1'b0, write: 1'b0, addr: ~addr, wdata: ~val};
        #1;
        if (!wr)
            check(reg_rdata, val);
    endtask

    // one access: decision in its own cycle, fault pulse in the next
    task automatic acc(input logic [31:0] a, input logic w, input logic f, input logic p,
                       input logic blk, input logic hard);
        u_rac_core_model.drive(a, w, f, p);
        #1;
        check(acc_block, blk);
        check(acc_grant, !blk);
        @(posedge clk);
        u_rac_core_model.idle();
        #1;
        check(memory_management_fault, blk && !hard);
        check(hard_fault_a, blk && hard);
    endtask

    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog: the sequence needs well under 1000 cycles
    initial
    begin
        #100us;
        num_errors++;
        end_sim();
    end

    // -----------------------------------------------
    // main sequence
    // -----------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        reg_op(0, `RAC_OFS_COUNT_INFO, 32'h0000_0800);
        reg_op(0, `RAC_OFS_CONTROL, 32'h0000_0000);
        reg_op(0, 32'hE000_EDBC, 32'h0000_0000);
        acc(32'h4000_0000, 0, 1, 0, 0, 0);
        check(acc_default_map, 1'b1);
        // attributes and regions go in before the enable
        reg_op(1, `RAC_OFS_ATTR_LOW, 32'h0000_AA00);
        reg_op(1, `RAC_OFS_ATTR_HIGH, 32'h0000_0055);
        reg_op(1, `RAC_OFS_SELECT, 32'h0000_0000);
        reg_op(1, `RAC_OFS_BASE, 32'h2000_0000);
        reg_op(1, `RAC_OFS_LIMIT, 32'h2000_03E3);
        reg_op(1, `RAC_OFS_BASE_A1, 32'h3000_0007);
        reg_op(1, `RAC_OFS_LIMIT_A1, 32'h3000_0FF9);
        reg_op(1, `RAC_OFS_BASE_A2, 32'h2000_03E0);
        reg_op(1, `RAC_OFS_LIMIT_A2, 32'h2000_03E1);
        reg_op(0, `RAC_OFS_LIMIT, 32'h2000_03E3);
        reg_op(0, `RAC_OFS_BASE_A1, 32'h3000_0007);
        reg_op(0, `RAC_OFS_SELECT, 32'h0000_0000);
        reg_op(1, `RAC_OFS_SELECT, 32'h0000_0001);
        reg_op(0, `RAC_OFS_BASE, 32'h3000_0007);
        reg_op(1, `RAC_OFS_SELECT, 32'h0000_0005);
        reg_op(1, `RAC_OFS_BASE_A3, 32'h5000_0000);
        reg_op(1, `RAC_OFS_SELECT, 32'h0000_0007);
        reg_op(0, `RAC_OFS_BASE, 32'h5000_0000);
        // a select beyond the implemented count reaches nothing
        reg_op(1, `RAC_OFS_SELECT, 32'h0000_0008);
        reg_op(1, `RAC_OFS_BASE, 32'h6000_0000);
        reg_op(0, `RAC_OFS_BASE, 32'h0000_0000);
        // region three: open to all, privileged execute never only
        reg_op(1, `RAC_OFS_SELECT, 32'h0000_0003);
        reg_op(1, `RAC_OFS_BASE, 32'h6000_0002);
        reg_op(1, `RAC_OFS_LIMIT, 32'h6000_0011);
        acc(32'h2000_0000, 0, 0, 0, 0, 0);
        reg_op(1, `RAC_OFS_CONTROL, 32'h0000_0001);
        for (int i = 0; i < 10; i++)
            acc(TAB[i][35:4], TAB[i][3], TAB[i][2], TAB[i][1], TAB[i][0], 0);
        reg_op(0, `RAC_OFS_FAULT_ADDR, 32'h4000_0000);
        reg_op(0, `RAC_OFS_FAULT_STATUS, 32'h0000_0082);
        acc(32'h2000_0000, 0, 0, 1, 0, 0);
        check(acc_attr, 8'hAA);
        acc(32'h3000_0010, 0, 0, 0, 0, 0);
        check(acc_attr, 8'h55);
        acc(32'h3000_0020, 0, 1, 1, 1, 0);
        acc(32'h6000_0000, 0, 1, 0, 0, 0);
        acc(32'h6000_0000, 0, 1, 1, 1, 0);
        reg_op(0, `RAC_OFS_FAULT_STATUS, 32'h0000_0081);
        // background map serves privileged misses only
        reg_op(1, `RAC_OFS_CONTROL, 32'h0000_0005);
        acc(32'h4000_0000, 0, 0, 1, 0, 0);
        check(acc_default_map, 1'b1);
        acc(32'h4000_0000, 0, 0, 0, 1, 0);
        mm_fault_can_take <= 1'b0;
        acc(32'h4000_0000, 0, 0, 0, 1, 1);
        mm_fault_can_take <= 1'b1;
        mm_fault_enabled <= 1'b0;
        acc(32'h4000_0000, 1, 0, 0, 1, 1);
        mm_fault_enabled <= 1'b1;
        // high priority handlers bypass checking unless asked not to
        acc_high_handler <= 1'b1;
        acc(32'h4000_0000, 0, 0, 0, 0, 0);
        reg_op(1, `RAC_OFS_CONTROL, 32'h0000_0007);
        acc(32'h4000_0000, 0, 0, 0, 1, 0);
        acc_high_handler <= 1'b0;
        reg_op(1, `RAC_OFS_CONTROL, 32'h0000_0000);
        acc(32'h4000_0000, 0, 0, 0, 0, 0);
        end_sim();
    end
endmodule
